// ---- ccm_cache_ctrl.sv ----
// cache configuration, control bits and maintenance decode
// Behaviour
// - line_bytes is one shifted left by line-length field plus three.
// - associativity field and multiplier give 1..128 or 3..192 ways.
// - zero associativity with multiplier set means cache absent, overriding all.
// - set_count is 1 << (size+6-assoc-len); negative shifts never reported.
// - control bit 2 enables data or unified cache, resets to zero.
// - without a cache bit 2 reads zero and ignores writes.
// - bit 3 enables write buffer; reads one if it cannot be disabled.
// - bit 12 enables separate instruction cache, else reads zero.
// - bit 14 selects predictable replacement, resets to zero.
// - privileged maintenance in user mode raises undefined instruction.
// - clean writes dirty line to memory then marks it clean.
// - invalidate marks target or all lines invalid.
// - invalidate-only discards dirty data unless clean-and-invalidate.
// - prefetch loads line, marks cacheable; abort means no memory access.
// - wait-for-interrupt halts until interrupt or enabled debug event.
// - on waking into handler, return link is instruction address plus eight.
// - prefetch flush forces refetch of following instructions.
// - barriers and prefetch flush allowed in user mode.
// - address operations need no alignment; all but prefetch do nothing on miss.
// - set/way data picks one line by set index and way.
// - low target bit picks cache or cache-like tightly coupled memory.
// - geometry field is 12 bits with documented layout.
// - way in top bits, set from bit L, target bit at zero.
`timescale 1ns/1ps
`default_nettype none
module ccm_cache_ctrl #(
    parameter logic [11:0] DGEO = 12'h192,
    parameter logic [11:0] IGEO = 12'h192,
    parameter bit SEPARATE = 1'b1,
    parameter bit DCACHE_PRESENT = 1'b1,
    parameter bit ICACHE_PRESENT = 1'b1,
    parameter bit WBUF_FIXED_ON = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // coprocessor transfer from the core
    input wire logic cpWrite,
    input wire logic cpRead,
    input wire logic [3:0] cpReg,
    input wire logic [3:0] cpCrm,
    input wire logic [2:0] opSelectField,
    input wire logic [31:0] cpWdata,
    input wire logic [31:0] instrAddr,
    input wire logic userMode,
    output logic [31:0] cpRdata,
    output logic undefInstr,
    // wake sources
    input wire logic irqPending,
    input wire logic debugReq,
    input wire logic debugEnable,
    input wire logic irqMasked,
    output logic waitHalt,
    output logic wakeToHandler,
    output logic [31:0] returnLink,
    // cache array side
    input wire logic lookupHit,
    input wire logic translateAbort,
    output logic maintValid,
    output ccm_pkg::ccm_op_e maintOp,
    output ccm_pkg::ccm_scope_e maintScope,
    output logic maintIcache,
    output logic maintDcache,
    output logic writeBackDirty,
    output logic dropDirty,
    output logic memAccess,
    output logic [31:0] modifiedVaddr,
    output logic [7:0] wayIndex,
    output logic [15:0] setIndex,
    output logic targetSelect,
    output logic prefetchFlush,
    output logic barrierSync,
    output logic barrierMem,
    // decoded geometry and control state
    output logic cacheAbsent,
    output logic [6:0] lineBytes,
    output logic [7:0] assocWays,
    output logic [15:0] setCount,
    output logic dcacheEnable,
    output logic icacheEnable,
    output logic wbufEnable,
    output logic predictableReplaceSel
);
    logic [31:0] ctlBits;
    ccm_pkg::ccm_state_e state;
    logic [1:0] len;
    logic [2:0] assoc;
    logic mult;
    logic [3:0] size;
    logic absentNow;
    logic [6:0] next_lineBytes;
    logic [7:0] next_ways;
    logic [4:0] shiftAmt;
    logic signed [6:0] setShift;
    logic [15:0] next_setCount;
    logic [3:0] waysLog;
    logic [2:0] lineLog;
    logic [4:0] setLog;
    logic ctlWr;
    logic mntWr;
    ccm_pkg::ccm_op_e decOp;
    ccm_pkg::ccm_scope_e decScope;
    logic decUserOk;
    logic decI;
    logic decD;
    logic wake;

    // geometry fields of the data or unified descriptor
    assign len = DGEO[ccm_pkg::GEO_LEN_HI:ccm_pkg::GEO_LEN_LO];
    assign assoc = DGEO[ccm_pkg::GEO_ASSOC_HI:ccm_pkg::GEO_ASSOC_LO];
    assign mult = DGEO[ccm_pkg::GEO_MULT];
    assign size = DGEO[ccm_pkg::GEO_SIZE_HI:ccm_pkg::GEO_SIZE_LO];

    // geometry decode; absent overrides every other field
    always_comb begin
        absentNow = (assoc == 3'h0) && mult;
        // widen before the bias is added so that len 1..3 cannot wrap
        next_lineBytes = 7'(7'h01 << (3'(len) + 3'(ccm_pkg::LEN_BIAS)));
        if (mult) begin
            next_ways = (assoc == 3'h0) ? 8'h00 : 8'(8'h03 << (assoc - 3'h1));
        end else begin
            next_ways = 8'(8'h01 << assoc);
        end
        setShift = 7'(size) + 7'(ccm_pkg::SETS_BIAS) - 7'(assoc) - 7'(len);
        shiftAmt = setShift[4:0];
        // invalid geometry is never reported as a set count
        if (absentNow || setShift < 0 || setShift > 7'sd15) begin
            next_setCount = 16'h0000;
        end else begin
            next_setCount = 16'(16'h0001 << shiftAmt);
        end
        if (absentNow) begin
            next_lineBytes = 7'h00;
            next_ways = 8'h00;
        end
    end

    // set/way field widths; way width rounds up for three-way multiples
    always_comb begin
        lineLog = 3'(len) + 3'(ccm_pkg::LEN_BIAS);
        setLog = (setShift < 0) ? 5'h00 : setShift[4:0];
        waysLog = mult ? 4'(assoc) + 4'h1 : 4'(assoc);
    end

    // registered geometry outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            cacheAbsent <= 1'b0;
            lineBytes <= 7'h00;
            assocWays <= 8'h00;
            setCount <= 16'h0000;
        end else begin
            cacheAbsent <= absentNow;
            lineBytes <= next_lineBytes;
            assocWays <= next_ways;
            setCount <= next_setCount;
        end
    end

    assign ctlWr = cpWrite && cpReg == 4'h1;
    assign mntWr = cpWrite && cpReg == 4'h7;

    // control register; absent units keep their bit at a fixed value
    always_ff @(posedge clk) begin
        if (rst) begin
            ctlBits <= ccm_pkg::CTL_RESET;
            ctlBits[ccm_pkg::CTL_WBUF] <= WBUF_FIXED_ON;
        end else if (ctlWr && !userMode) begin
            ctlBits <= cpWdata;
            ctlBits[ccm_pkg::CTL_DCACHE] <= DCACHE_PRESENT && !absentNow
                && cpWdata[ccm_pkg::CTL_DCACHE];
            ctlBits[ccm_pkg::CTL_WBUF] <= WBUF_FIXED_ON
                || cpWdata[ccm_pkg::CTL_WBUF];
            ctlBits[ccm_pkg::CTL_ICACHE] <= SEPARATE && ICACHE_PRESENT
                && cpWdata[ccm_pkg::CTL_ICACHE];
            ctlBits[ccm_pkg::CTL_REPL] <= cpWdata[ccm_pkg::CTL_REPL];
        end
    end

    // steering outputs follow the control register one cycle later
    always_ff @(posedge clk) begin
        if (rst) begin
            dcacheEnable <= 1'b0;
            icacheEnable <= 1'b0;
            wbufEnable <= 1'b0;
            predictableReplaceSel <= 1'b0;
            cpRdata <= 32'h0000_0000;
        end else begin
            dcacheEnable <= ctlBits[ccm_pkg::CTL_DCACHE];
            icacheEnable <= ctlBits[ccm_pkg::CTL_ICACHE];
            wbufEnable <= ctlBits[ccm_pkg::CTL_WBUF];
            predictableReplaceSel <= ctlBits[ccm_pkg::CTL_REPL];
            // maintenance register is write-only and reads as zero
            cpRdata <= (cpRead && cpReg == 4'h1) ? ctlBits : 32'h0000_0000;
        end
    end

    // maintenance decode; unlisted combinations become no operation
    always_comb begin
        decOp = ccm_pkg::OP_NONE;
        decScope = ccm_pkg::SCOPE_ALL;
        decUserOk = 1'b0;
        decI = 1'b0;
        decD = 1'b0;
        case (opSelectField)
            ccm_pkg::OPS_VADDR: decScope = ccm_pkg::SCOPE_VADDR;
            ccm_pkg::OPS_SETWAY: decScope = ccm_pkg::SCOPE_SETWAY;
        endcase
        case (cpCrm)
            ccm_pkg::CRM_WAIT: begin
                if (opSelectField == ccm_pkg::OPS_WAIT) decOp = ccm_pkg::OP_WAIT;
            end
            ccm_pkg::CRM_INV_I: begin
                decI = 1'b1;
                if (opSelectField <= ccm_pkg::OPS_SETWAY) decOp = ccm_pkg::OP_INV;
                if (opSelectField == ccm_pkg::OPS_PFLUSH) begin
                    decOp = ccm_pkg::OP_PFLUSH;
                    decUserOk = 1'b1;
                end
            end
            ccm_pkg::CRM_INV_D, ccm_pkg::CRM_INV_U: begin
                decD = 1'b1;
                decI = (cpCrm == ccm_pkg::CRM_INV_U) && opSelectField == ccm_pkg::OPS_ALL;
                if (opSelectField <= ccm_pkg::OPS_SETWAY) decOp = ccm_pkg::OP_INV;
            end
            ccm_pkg::CRM_CLN_D, ccm_pkg::CRM_CLN_U: begin
                decD = 1'b1;
                if (opSelectField <= ccm_pkg::OPS_SETWAY) decOp = ccm_pkg::OP_CLEAN;
                if (cpCrm == ccm_pkg::CRM_CLN_D && opSelectField == ccm_pkg::OPS_SYNC) begin
                    decOp = ccm_pkg::OP_SYNC;
                    decUserOk = 1'b1;
                end
                if (cpCrm == ccm_pkg::CRM_CLN_D && opSelectField == ccm_pkg::OPS_MEMB) begin
                    decOp = ccm_pkg::OP_MEMB;
                    decUserOk = 1'b1;
                end
            end
            ccm_pkg::CRM_PREF: begin
                decI = 1'b1;
                if (opSelectField == ccm_pkg::OPS_VADDR) decOp = ccm_pkg::OP_PREFETCH;
            end
            ccm_pkg::CRM_CI_D, ccm_pkg::CRM_CI_U: begin
                decD = 1'b1;
                if (opSelectField <= ccm_pkg::OPS_SETWAY) decOp = ccm_pkg::OP_CLEAN_INV;
            end
            default: decOp = ccm_pkg::OP_NONE;
        endcase
    end

    // issue of maintenance commands toward the cache array
    always_ff @(posedge clk) begin
        if (rst) begin
            maintValid <= 1'b0;
            maintOp <= ccm_pkg::OP_NONE;
            maintScope <= ccm_pkg::SCOPE_ALL;
            maintIcache <= 1'b0;
            maintDcache <= 1'b0;
            undefInstr <= 1'b0;
            modifiedVaddr <= 32'h0000_0000;
            wayIndex <= 8'h00;
            setIndex <= 16'h0000;
            targetSelect <= 1'b0;
            prefetchFlush <= 1'b0;
            barrierSync <= 1'b0;
            barrierMem <= 1'b0;
        end else begin
            undefInstr <= mntWr && userMode && !decUserOk;
            maintValid <= mntWr && (!userMode || decUserOk) && decOp != ccm_pkg::OP_NONE;
            maintOp <= decOp;
            maintScope <= decScope;
            maintIcache <= decI;
            maintDcache <= decD;
            prefetchFlush <= mntWr && decOp == ccm_pkg::OP_PFLUSH;
            barrierSync <= mntWr && decOp == ccm_pkg::OP_SYNC;
            barrierMem <= mntWr && decOp == ccm_pkg::OP_MEMB;
            if (mntWr) begin
                modifiedVaddr <= cpWdata;
                wayIndex <= 8'((cpWdata >> (6'd32 - 6'(waysLog))) & 32'h0000_00ff);
                setIndex <= 16'((cpWdata >> lineLog) & ((32'h1 << setLog) - 32'h1));
                targetSelect <= cpWdata[0];
            end
        end
    end

    // array answer: dirty handling and memory traffic for the issued op
    always_ff @(posedge clk) begin
        if (rst) begin
            writeBackDirty <= 1'b0;
            dropDirty <= 1'b0;
            memAccess <= 1'b0;
        end else begin
            // vaddr ops other than prefetch do nothing on a miss
            writeBackDirty <= maintValid && lookupHit && (maintOp == ccm_pkg::OP_CLEAN
                || maintOp == ccm_pkg::OP_CLEAN_INV);
            dropDirty <= maintValid && lookupHit && maintOp == ccm_pkg::OP_INV
                && maintDcache;
            memAccess <= maintValid && maintOp == ccm_pkg::OP_PREFETCH
                && !translateAbort;
        end
    end

    // wake even when masked; enabled debug also wakes
    assign wake = irqPending || (debugReq && debugEnable);

    // wait-for-interrupt state
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ccm_pkg::ST_IDLE;
            waitHalt <= 1'b0;
            wakeToHandler <= 1'b0;
            returnLink <= 32'h0000_0000;
        end else begin
            wakeToHandler <= 1'b0;
            case (state)
                ccm_pkg::ST_IDLE: begin
                    if (mntWr && !userMode && decOp == ccm_pkg::OP_WAIT) begin
                        state <= ccm_pkg::ST_WAIT_IRQ;
                        waitHalt <= 1'b1;
                        returnLink <= instrAddr + ccm_pkg::RET_OFFSET;
                    end
                end
                ccm_pkg::ST_WAIT_IRQ: begin
                    if (wake) begin
                        state <= ccm_pkg::ST_IDLE;
                        waitHalt <= 1'b0;
                        wakeToHandler <= irqPending && !irqMasked;
                    end
                end
                default: state <= ccm_pkg::ST_IDLE;
            endcase
        end
    end

    // checks
    userPriv_a: assert property (@(posedge clk) disable iff (rst)
        mntWr && userMode && !decUserOk |=> undefInstr && !maintValid)
        else $error("user privileged op not refused");
    barrierUser_a: assert property (@(posedge clk) disable iff (rst)
        mntWr && userMode && decOp == ccm_pkg::OP_SYNC |=> barrierSync && !undefInstr)
        else $error("barrier refused in user mode");
    lineBytes_a: assert property (@(posedge clk) disable iff (rst)
        !absentNow |=> lineBytes == 7'(7'h08 << $past(len)))
        else $error("line length wrong");
    absent_a: assert property (@(posedge clk) disable iff (rst)
        cacheAbsent |-> assocWays == 8'h00 && setCount == 16'h0000)
        else $error("absent cache reports geometry");
    dcacheOff_a: assert property (@(posedge clk) disable iff (rst)
        absentNow || !DCACHE_PRESENT || ctlWr && !userMode && !cpWdata[ccm_pkg::CTL_DCACHE]
        |=> !ctlBits[ccm_pkg::CTL_DCACHE]) else $error("data cache bit not cleared");
    wbufFixed_a: assert property (@(posedge clk) disable iff (rst)
        WBUF_FIXED_ON || ctlWr && !userMode && cpWdata[ccm_pkg::CTL_WBUF]
        |=> ctlBits[ccm_pkg::CTL_WBUF]) else $error("write buffer bit not set");
    icacheUni_a: assert property (@(posedge clk) disable iff (rst)
        !SEPARATE || !ICACHE_PRESENT || ctlWr && !userMode && !cpWdata[ccm_pkg::CTL_ICACHE]
        |=> !ctlBits[ccm_pkg::CTL_ICACHE]) else $error("icache bit not cleared");
    waitLink_a: assert property (@(posedge clk) disable iff (rst)
        state == ccm_pkg::ST_IDLE && mntWr && !userMode && decOp == ccm_pkg::OP_WAIT
        |=> waitHalt && returnLink == $past(instrAddr) + 32'h0000_0008)
        else $error("wait entry or link wrong");
    abortNoMem_a: assert property (@(posedge clk) disable iff (rst)
        translateAbort |=> !memAccess)
        else $error("memory access after abort");
    missNoEffect_a: assert property (@(posedge clk) disable iff (rst)
        !lookupHit |=> !writeBackDirty && !dropDirty)
        else $error("miss changed a line");
    resetCtl_a: assert property (@(posedge clk)
        rst |=> !ctlBits[ccm_pkg::CTL_DCACHE] && !ctlBits[ccm_pkg::CTL_REPL])
        else $error("control bits not reset");
endmodule
`default_nettype wire

// ---- ccm_pkg.sv ----
// package: constants for the cache control and maintenance block
package ccm_pkg;
    // geometry field layout
    localparam int GEO_PBIT = 11;
    localparam int GEO_SIZE_HI = 9;
    localparam int GEO_SIZE_LO = 6;
    localparam int GEO_ASSOC_HI = 5;
    localparam int GEO_ASSOC_LO = 3;
    localparam int GEO_MULT = 2;
    localparam int GEO_LEN_HI = 1;
    localparam int GEO_LEN_LO = 0;
    localparam int LEN_BIAS = 3;
    localparam int SETS_BIAS = 6;
    // control bit positions
    localparam int CTL_DCACHE = 2;
    localparam int CTL_WBUF = 3;
    localparam int CTL_ICACHE = 12;
    localparam int CTL_REPL = 14;
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;
    // secondary register codes of maintenance writes
    localparam logic [3:0] CRM_WAIT = 4'h0;
    localparam logic [3:0] CRM_INV_I = 4'h5;
    localparam logic [3:0] CRM_INV_D = 4'h6;
    localparam logic [3:0] CRM_INV_U = 4'h7;
    localparam logic [3:0] CRM_CLN_D = 4'ha;
    localparam logic [3:0] CRM_CLN_U = 4'hb;
    localparam logic [3:0] CRM_PREF = 4'hd;
    localparam logic [3:0] CRM_CI_D = 4'he;
    localparam logic [3:0] CRM_CI_U = 4'hf;
    // op_select_field codes
    localparam logic [2:0] OPS_ALL = 3'h0;
    localparam logic [2:0] OPS_VADDR = 3'h1;
    localparam logic [2:0] OPS_SETWAY = 3'h2;
    localparam logic [2:0] OPS_WAIT = 3'h4;
    localparam logic [2:0] OPS_SYNC = 3'h4;
    localparam logic [2:0] OPS_MEMB = 3'h5;
    localparam logic [2:0] OPS_PFLUSH = 3'h4;
    localparam logic [31:0] RET_OFFSET = 32'h0000_0008;
    // maintenance operation kinds
    typedef enum logic [3:0] {
        OP_NONE, OP_INV, OP_CLEAN, OP_CLEAN_INV, OP_PREFETCH,
        OP_WAIT, OP_PFLUSH, OP_SYNC, OP_MEMB
    } ccm_op_e;
    typedef enum logic [1:0] {
        SCOPE_ALL, SCOPE_VADDR, SCOPE_SETWAY
    } ccm_scope_e;
    typedef enum logic [1:0] {
        ST_IDLE, ST_WAIT_IRQ
    } ccm_state_e;
endpackage

// ---- ccm_core_model.sv ----
// processor core model that issues coprocessor transfers
`timescale 1ns/1ps
`default_nettype none
module ccm_core_model (
    // clock
    input wire logic clk,
    // transfer toward the block
    output logic cpWrite,
    output logic cpRead,
    output logic [3:0] cpReg,
    output logic [3:0] cpCrm,
    output logic [2:0] opSelectField,
    output logic [31:0] cpWdata,
    output logic [31:0] instrAddr,
    output logic userMode
);
    // idle bus at time zero
    initial begin
        {cpWrite, cpRead, cpReg, cpCrm, opSelectField, cpWdata, instrAddr, userMode} = '0;
    end
    // one transfer, raised after a falling edge and held one full cycle
    task automatic xfer(input logic wr, input logic [3:0] rg, cm, input logic [2:0] op,
                        input logic [31:0] d, ia, input logic usr);
        @(negedge clk);
        cpWrite = wr;
        cpRead = !wr;
        cpReg = rg;
        cpCrm = cm;
        opSelectField = op;
        cpWdata = d;
        instrAddr = ia;
        userMode = usr;
        @(negedge clk);
        cpWrite = 1'b0;
        cpRead = 1'b0;
        // released data must not keep its old value
        cpWdata = ~d;
    endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// self-checking bench for the cache control and maintenance block
`timescale 1ns/1ps
`default_nettype none
module tb;
    // 16-byte lines, 12 ways through the multiplier, 1024 sets
    localparam logic [11:0] GEO = 12'h21d;
    logic clk, rst, cpWrite, cpRead, userMode, undefInstr, waitHalt, wakeToHandler;
    logic irqPending, debugReq, debugEnable, irqMasked, lookupHit, translateAbort;
    logic maintValid, maintIcache, maintDcache, writeBackDirty, dropDirty, memAccess;
    logic targetSelect, prefetchFlush, barrierSync, barrierMem, cacheAbsent;
    logic dcacheEnable, icacheEnable, wbufEnable, predictableReplaceSel;
    logic [3:0] cpReg, cpCrm;
    logic [2:0] opSelectField;
    logic [31:0] cpWdata, instrAddr, cpRdata, returnLink, modifiedVaddr;
    logic [7:0] wayIndex, assocWays;
    logic [15:0] setIndex, setCount;
    logic [6:0] lineBytes;
    ccm_pkg::ccm_op_e maintOp;
    ccm_pkg::ccm_scope_e maintScope;
    int numErrors = 0;
    int nChecks = 0;

    ccm_core_model i_core (.clk(clk), .cpWrite(cpWrite), .cpRead(cpRead), .cpReg(cpReg),
        .cpCrm(cpCrm), .opSelectField(opSelectField), .cpWdata(cpWdata),
        .instrAddr(instrAddr), .userMode(userMode));

    ccm_cache_ctrl #(.DGEO(GEO)) i_dut (.clk(clk), .rst(rst), .cpWrite(cpWrite),
        .cpRead(cpRead), .cpReg(cpReg), .cpCrm(cpCrm), .opSelectField(opSelectField),
        .cpWdata(cpWdata), .instrAddr(instrAddr), .userMode(userMode), .cpRdata(cpRdata),
        .undefInstr(undefInstr), .irqPending(irqPending), .debugReq(debugReq),
        .debugEnable(debugEnable), .irqMasked(irqMasked), .waitHalt(waitHalt),
        .wakeToHandler(wakeToHandler), .returnLink(returnLink), .lookupHit(lookupHit),
        .translateAbort(translateAbort), .maintValid(maintValid), .maintOp(maintOp),
        .maintScope(maintScope), .maintIcache(maintIcache), .maintDcache(maintDcache),
        .writeBackDirty(writeBackDirty), .dropDirty(dropDirty), .memAccess(memAccess),
        .modifiedVaddr(modifiedVaddr), .wayIndex(wayIndex), .setIndex(setIndex),
        .targetSelect(targetSelect), .prefetchFlush(prefetchFlush),
        .barrierSync(barrierSync), .barrierMem(barrierMem), .cacheAbsent(cacheAbsent),
        .lineBytes(lineBytes), .assocWays(assocWays), .setCount(setCount),
        .dcacheEnable(dcacheEnable), .icacheEnable(icacheEnable), .wbufEnable(wbufEnable),
        .predictableReplaceSel(predictableReplaceSel));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // one compare for every value result
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // verdict and end of run
    task automatic summarize();
        $display("checks %0d errors %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // expected kind: 1 inv, 2 clean, 3 clean+inv, 4 prefetch, 6 flush, 7 sync, 8 memory
    function automatic int kind_of(input int c, input int o);
        if (o < 3 && c inside {5, 6, 7}) return 1;
        if (o < 3 && c inside {10, 11}) return 2;
        if (o < 3 && c inside {14, 15}) return 3;
        if (c == 13 && o == 1) return 4;
        if (c == 5 && o == 4) return 6;
        if (c == 10 && o >= 4) return o + 3;
        return 0;
    endfunction

    // main sequence; ctl is the bench's copy of the control word
    initial begin
        logic [31:0] d, a, ctl;
        logic u, hit, ab, ok;
        int k, n;
        {rst, irqPending, debugReq, debugEnable, irqMasked, lookupHit, translateAbort} = 7'h40;
        ctl = 32'h0;
        d = $urandom(30660);
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        chk(32'(lineBytes), 32'h10);
        chk(32'(assocWays), 32'hc);
        chk(32'(cacheAbsent), 32'h0);
        chk(32'(setCount), 32'h400);
        chk(32'({dcacheEnable, icacheEnable, predictableReplaceSel}), 32'h0);
        // control word: all ones, all zeros, then random, some in user mode
        for (int i = 0; i < 10; i++) begin
            d = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $urandom;
            u = (i > 1) && ($urandom % 3 == 0);
            i_core.xfer(1'b1, 4'h1, 4'h0, 3'h0, d, 32'h0, u);
            if (!u) ctl = d;
            repeat (2) @(negedge clk);
            chk(32'(dcacheEnable), 32'(ctl[2]));
            chk(32'(wbufEnable), 32'(ctl[3]));
            chk(32'(icacheEnable), 32'(ctl[12]));
            chk(32'(predictableReplaceSel), 32'(ctl[14]));
            i_core.xfer(1'b0, 4'h1, 4'h0, 3'h0, 32'h0, 32'h0, 1'b0);
            // read data stands only in the cycle after the read strobe
            chk(cpRdata & 32'h500c, ctl & 32'h500c);
        end
        // every listed maintenance code except wait, plus one unlisted
        for (int c = 1; c < 16; c++) begin
            for (int o = 0; o < 6; o++) begin
                k = kind_of(c, o);
                if (k == 0 && !(c == 1 && o == 0)) continue;
                d = $urandom;
                hit = $urandom % 2;
                ab = $urandom % 2;
                u = (k >= 6) || (k > 0 && $urandom % 2 == 1);
                lookupHit = hit;
                translateAbort = ab;
                i_core.xfer(1'b1, 4'h7, 4'(c), 3'(o), d, 32'h0, u);
                // issue pulses stand one cycle; flush and barriers issue in any mode
                ok = (k >= 1 && k <= 4 && !u) || k >= 6;
                chk(32'(undefInstr), 32'(k >= 1 && k <= 4 && u));
                chk(32'(maintValid), 32'(ok));
                chk(32'({prefetchFlush, barrierSync, barrierMem}),
                    32'({k == 6, k == 7, k == 8}));
                if (ok) begin
                    chk(32'(maintOp), 32'(k));
                    if (k < 4) chk(32'(maintScope), 32'(o));
                    if (c inside {5, 6, 10, 14} || (c == 7 && o == 0))
                        chk(32'({maintIcache, maintDcache}), 32'({c inside {5, 7}, c != 5}));
                    if (o == 1) chk(modifiedVaddr, d);
                    if (o == 2) begin
                        chk(32'(wayIndex), 32'(d[31:28]));
                        chk(32'(setIndex), 32'(d[13:4]));
                        chk(32'(targetSelect), 32'(d[0]));
                    end
                end
                @(negedge clk);
                if (ok && o == 1 && k == 2) chk(32'(writeBackDirty), 32'(hit));
                if (ok && o == 1 && k == 3)
                    chk(32'({writeBackDirty, dropDirty}), 32'({hit, 1'b0}));
                if (ok && o == 1 && k == 1 && c != 5) chk(32'(dropDirty), 32'(hit));
                chk(32'(memAccess), 32'(ok && k == 4 && !ab));
            end
        end
        // wait: masked irq, unmasked irq, enabled debug event
        for (int w = 0; w < 3; w++) begin
            a = $urandom & 32'hffff_fffc;
            i_core.xfer(1'b1, 4'h7, 4'h0, 3'h4, 32'h0, a, 1'b0);
            @(negedge clk);
            chk(32'(waitHalt), 32'h1);
            chk(returnLink, a + 32'h8);
            debugReq = 1'b1;
            repeat (3) @(negedge clk);
            chk(32'(waitHalt), 32'h1);
            {irqPending, irqMasked, debugReq, debugEnable} = {w < 2, w == 0, w == 2, w == 2};
            n = 0;
            while (waitHalt === 1'b1 && n < 4) begin
                @(negedge clk);
                n++;
            end
            if (waitHalt !== 1'b0) begin
                numErrors++;
                summarize();
            end
            chk(32'(wakeToHandler), 32'(w == 1));
            {irqPending, irqMasked, debugReq, debugEnable} = 4'h0;
            @(negedge clk);
            chk(32'(wakeToHandler), 32'h0);
        end
        // second reset clears the enables again
        i_core.xfer(1'b1, 4'h1, 4'h0, 3'h0, 32'h500c, 32'h0, 1'b0);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        chk(32'({dcacheEnable, icacheEnable, wbufEnable, predictableReplaceSel}), 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
